// *** logic/adc_conflict_sequencing.sv ***
// Sequencer of an 8-bit successive-approximation converter with its conflict handling
`timescale 1ns/1ps

// What this block does
// - A result read colliding with the end-of-conversion write is served first, then stored.
// - Trigger edges are ignored while converting, including the result-write cycle.
// - Mode or channel write at conversion end wins: no result update, no interrupt.
// - Standby stops conversion; clearing enable bit 7 also stops it.
// - A channel write leaves the done flag untouched.
// - A conversion finishing just before a channel write still updates result and flag.
// - Mode or channel writes may spoil the result; software reads it first.
// - Completion colliding with a stop may spoil the result; read while running.
// - Sample for about a tenth of the conversion, then hold for comparisons.
// - Conversion time counts from sampling start to result, sampling included.
// - Result is 8 bits, one step per comparison, MSB first.
// - Every conversion end without a mode or channel write or a colliding read stores the result and raises the interrupt together.
// - A mode or channel write aborts the conversion and restarts it if enabled.
module adc_conflict_sequencing
   import adc_seq_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic mode_wr_i,
   input wire logic [7:0] mode_data_i,
   input wire logic chan_wr_i,
   input wire logic [CHAN_W-1:0] chan_data_i,
   input wire logic result_rd_i,
   input wire logic flag_clr_i,
   input wire logic standby_i,
   input wire logic ext_trigger_i,
   input wire logic comparator_i,
   output logic [RES_BITS-1:0] conversion_result_reg_o,
   output logic [RES_BITS-1:0] rd_data_o,
   output logic [7:0] converter_mode_reg_o,
   output logic [CHAN_W-1:0] channel_select_reg_o,
   output logic conversion_done_flag_o,
   output logic conversion_done_irq_o,
   output logic booster_enable_o,
   output logic [RES_BITS-1:0] sar_trial_o,
   output logic sample_o,
   output logic busy_o
);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic trig_meta;
   logic trig_sync;
   logic trig_prev;
   logic comp_meta;
   logic comp_sync;

   // Trigger pin and comparator are asynchronous; two stages before use
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         trig_meta <= 1'b0;
         trig_sync <= 1'b0;
         trig_prev <= 1'b0;
         comp_meta <= 1'b0;
         comp_sync <= 1'b0;
      end else begin
         trig_meta <= ext_trigger_i;
         trig_sync <= trig_meta;
         trig_prev <= trig_sync;
         comp_meta <= comparator_i;
         comp_sync <= comp_meta;
      end
   end

   // ------------------------------------------------------------
   // Conversion state
   // ------------------------------------------------------------
   conv_state_t state, next_state;
   mode_t mode, next_mode;
   logic [CHAN_W-1:0] chan, next_chan;
   logic [RES_BITS-1:0] sar, next_sar;
   logic [2:0] bit_idx, next_bit_idx;
   logic [STEP_W-1:0] step, next_step;
   logic [CNT_W-1:0] conv_cnt, next_conv_cnt;
   logic [RES_BITS-1:0] result, next_result;
   logic pend, next_pend;
   logic [RES_BITS-1:0] pend_val, next_pend_val;
   logic flag, next_flag;
   logic irq, next_irq;
   logic [RES_BITS-1:0] rd_data, next_rd_data;
   logic reg_wr;
   logic trig_edge;
   logic step_end;
   logic done_raw;
   logic done_now;
   logic flag_set;
   logic [RES_BITS-1:0] sar_decided;

   assign reg_wr = mode_wr_i | chan_wr_i;
   assign step_end = (state == CONVERT) && (step == STEP_W'(STEP_CYCLES - 1));
   assign done_raw = step_end && (bit_idx == 3'h0);
   assign done_now = done_raw && !reg_wr;

   // Edge detection looks only at the second and third stages
   always_comb begin
      case (mode.edge_sel)
         EDGE_FALL: trig_edge = trig_prev & ~trig_sync;
         EDGE_RISE: trig_edge = ~trig_prev & trig_sync;
         EDGE_BOTH: trig_edge = trig_prev ^ trig_sync;
         default: trig_edge = 1'b0;
      endcase
   end

   // Decided bit replaces the trial bit; the next lower bit becomes the trial
   always_comb begin
      sar_decided = sar;
      sar_decided[bit_idx] = comp_sync;
      if (bit_idx != 3'h0) begin
         sar_decided[bit_idx - 3'h1] = 1'b1;
      end
   end

   // Next-value computation; register writes override the conversion but not a pending store or a stop
   always_comb begin
      next_state = state;
      next_mode = mode;
      next_chan = chan;
      next_sar = sar;
      next_bit_idx = bit_idx;
      next_step = step;
      next_conv_cnt = conv_cnt;
      next_result = result;
      next_pend = 1'b0;
      next_pend_val = pend_val;
      next_irq = 1'b0;
      next_rd_data = rd_data;
      flag_set = 1'b0;
      // Read always sees the value held before any store in this cycle
      if (result_rd_i) begin
         next_rd_data = result;
      end
      // Deferred store after a colliding read
      if (pend) begin
         next_result = pend_val;
         next_irq = 1'b1;
         flag_set = 1'b1;
      end
      case (state)
         IDLE: begin
            if (mode.conversion_enable) begin
               next_state = mode.hw_trigger ? WAIT_TRIG : SAMPLE;
               next_conv_cnt = '0;
            end
         end
         WAIT_TRIG: begin
            // Edges count only here, never while sampling or converting
            if (trig_edge) begin
               next_state = SAMPLE;
               next_conv_cnt = '0;
            end
         end
         SAMPLE: begin
            next_conv_cnt = conv_cnt + CNT_W'(1);
            if (conv_cnt == CNT_W'(SAMPLE_CYCLES - 1)) begin
               next_state = CONVERT;
               next_sar = SAR_FIRST_TRIAL;
               next_bit_idx = MSB_INDEX;
               next_step = '0;
            end
         end
         CONVERT: begin
            next_conv_cnt = conv_cnt + CNT_W'(1);
            next_step = step + STEP_W'(1);
            if (step_end) begin
               next_sar = sar_decided;
               next_bit_idx = bit_idx - 3'h1;
               next_step = '0;
            end
            if (done_now) begin
               // Store and interrupt together unless a read collides
               if (result_rd_i) begin
                  next_pend = 1'b1;
                  next_pend_val = sar_decided;
               end else begin
                  next_result = sar_decided;
                  next_irq = 1'b1;
                  flag_set = 1'b1;
               end
               next_state = mode.hw_trigger ? WAIT_TRIG : SAMPLE;
               next_conv_cnt = '0;
            end
         end
         default: begin
            next_state = IDLE;
         end
      endcase
      // Register writes abort and restart; they never touch the done flag
      if (reg_wr) begin
         if (mode_wr_i) begin
            next_mode = mode_t'(mode_data_i);
         end
         if (chan_wr_i) begin
            next_chan = chan_data_i;
         end
         next_state = next_mode.hw_trigger ? WAIT_TRIG : SAMPLE;
         next_conv_cnt = '0;
      end
      // Stop wins over any running conversion; clearing enable also saves power
      if (!next_mode.conversion_enable || standby_i) begin
         next_state = IDLE;
         next_conv_cnt = '0;
      end
      // Set wins over a clear arriving in the same cycle
      next_flag = (flag & ~flag_clr_i) | flag_set;
   end

   // State registers
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         state <= IDLE;
         mode <= mode_t'(MODE_RESET);
         chan <= CHAN_RESET;
         sar <= '0;
         bit_idx <= '0;
         step <= '0;
         conv_cnt <= '0;
         result <= RESULT_RESET;
         pend <= 1'b0;
         pend_val <= '0;
         flag <= 1'b0;
         irq <= 1'b0;
         rd_data <= '0;
      end else begin
         state <= next_state;
         mode <= next_mode;
         chan <= next_chan;
         sar <= next_sar;
         bit_idx <= next_bit_idx;
         step <= next_step;
         conv_cnt <= next_conv_cnt;
         result <= next_result;
         pend <= next_pend;
         pend_val <= next_pend_val;
         flag <= next_flag;
         irq <= next_irq;
         rd_data <= next_rd_data;
      end
   end

   // Outputs
   assign conversion_result_reg_o = result;
   assign rd_data_o = rd_data;
   assign converter_mode_reg_o = mode;
   assign channel_select_reg_o = chan;
   assign conversion_done_flag_o = flag;
   assign conversion_done_irq_o = irq;
   assign booster_enable_o = mode.booster_enable;
   assign sar_trial_o = sar;
   assign sample_o = (state == SAMPLE);
   assign busy_o = (state == SAMPLE) || (state == CONVERT);

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence seq_read_clash;
      done_now && result_rd_i;
   endsequence
   sequence seq_old_then_new;
      (rd_data_o == $past(result)) && !irq ##1 irq && (result == $past(pend_val));
   endsequence
   AST_READ_FIRST: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      seq_read_clash |=> seq_old_then_new) else $error("colliding read not served before store");
   AST_TRIG_IGNORED: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (state == CONVERT) && trig_edge && !reg_wr && !done_raw && mode.conversion_enable && !standby_i
      |=> (state == CONVERT) && (conv_cnt == $past(conv_cnt) + CNT_W'(1))) else $error("trigger restarted conversion");
   AST_WRITE_WINS: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      done_raw && reg_wr && !pend |=> !irq && $stable(result)) else $error("result stored despite register write");
   AST_STANDBY_STOP: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      standby_i |=> (state == IDLE) && !busy_o) else $error("conversion running in standby");
   AST_CHAN_KEEPS_FLAG: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      chan_wr_i && flag && !flag_clr_i |=> flag) else $error("channel write cleared done flag");
   AST_IRQ_WITH_FLAG: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      irq |-> flag) else $error("irq without flag");
   AST_STORE_WITH_IRQ: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      done_now && !result_rd_i |=> irq && flag && (result == $past(sar_decided)))
      else $error("result not stored together with irq");
   AST_SAMPLE_LEN: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      (state == SAMPLE) && !reg_wr && mode.conversion_enable && !standby_i
      && (conv_cnt == CNT_W'(SAMPLE_CYCLES - 1)) |=> (state == CONVERT) && (sar == SAR_FIRST_TRIAL))
      else $error("sampling length wrong");
   AST_CONV_TIME: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      done_now |-> conv_cnt == CNT_W'(CONV_CYCLES - 1)) else $error("conversion time wrong");
   AST_ABORT_RESTART: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
      reg_wr && busy_o && mode_wr_i && mode_data_i[7] && !mode_data_i[6] && !standby_i
      |=> (state == SAMPLE) && (conv_cnt == '0) ##1 ((conv_cnt == CNT_W'(1)) || !sample_o))
      else $error("register write did not restart conversion");

endmodule

// *** logic/adc_seq_pkg.sv ***
// Constants and types shared by the converter sequencing block
package adc_seq_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int CONV_TIME_NS = 14400;
   localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
   // Sampling takes about one tenth of the whole conversion
   localparam int SAMPLE_CYCLES = CONV_CYCLES / 10;
   localparam int RES_BITS = 8;
   localparam int STEP_CYCLES = (CONV_CYCLES - SAMPLE_CYCLES) / RES_BITS;

   // ------------------------------------------------------------
   // Field widths and reset values
   // ------------------------------------------------------------
   localparam int CNT_W = 12;
   localparam int STEP_W = 8;
   localparam int CHAN_W = 3;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [CHAN_W-1:0] CHAN_RESET = 3'h0;
   localparam logic [RES_BITS-1:0] RESULT_RESET = 8'h00;
   localparam logic [RES_BITS-1:0] SAR_FIRST_TRIAL = 8'h80;
   localparam logic [2:0] MSB_INDEX = 3'h7;

   // Trigger edge selection codes
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_FALL = 2'h1;
   localparam logic [1:0] EDGE_RISE = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   // Mode register layout, bit 7 down to bit 0
   typedef struct packed {
      logic conversion_enable;
      logic hw_trigger;
      logic [2:0] conv_time_sel;
      logic [1:0] edge_sel;
      logic booster_enable;
   } mode_t;

   typedef enum logic [1:0] {IDLE, WAIT_TRIG, SAMPLE, CONVERT} conv_state_t;

endpackage

// *** sim/adc_analog_model.sv ***
// Analog side: one input level compared against the converter's trial tap
`timescale 1ns/1ps

module adc_analog_model (
   input wire logic [7:0] sar_trial_i,
   input wire logic [7:0] level_i,
   output logic comparator_o
);
   // ------------------------------------------------------------
   // Comparator
   // ------------------------------------------------------------
   // Input at or above the tap answers 1, so the SAR settles on level_i
   assign comparator_o = (level_i >= sar_trial_i);
endmodule

// *** sim/adc_conflict_sequencing_bench.sv ***
// Self-checking bench for the converter sequencer and its conflict cases
`timescale 1ns/1ps

module adc_conflict_sequencing_bench;
   import adc_seq_pkg::*;
   logic core_clk_i = 0, sys_rst_i = 1, mode_wr_i = 0, chan_wr_i = 0, result_rd_i = 0;
   logic flag_clr_i = 0, standby_i = 0, ext_trigger_i = 0, comparator_i;
   logic [7:0] mode_data_i = 8'h00, level = 8'h00, old, mode_o;
   logic [CHAN_W-1:0] chan_data_i = 3'h0, chan_o, ch;
   logic [7:0] result, rd_data, trial;
   logic flag, irq, boost, sample, busy;
   int n_mismatch = 0, n_compared = 0, seed = 32, cnt;

   adc_conflict_sequencing adc_conflict_sequencing_inst (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
      .mode_wr_i(mode_wr_i), .mode_data_i(mode_data_i), .chan_wr_i(chan_wr_i), .chan_data_i(chan_data_i),
      .result_rd_i(result_rd_i), .flag_clr_i(flag_clr_i), .standby_i(standby_i),
      .ext_trigger_i(ext_trigger_i), .comparator_i(comparator_i), .conversion_result_reg_o(result),
      .rd_data_o(rd_data), .converter_mode_reg_o(mode_o), .channel_select_reg_o(chan_o),
      .conversion_done_flag_o(flag), .conversion_done_irq_o(irq), .booster_enable_o(boost),
      .sar_trial_o(trial), .sample_o(sample), .busy_o(busy));
   adc_analog_model adc_analog_model_inst (.sar_trial_i(trial), .level_i(level), .comparator_o(comparator_i));

   initial begin
      forever #5 core_clk_i = ~core_clk_i;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic end_of_test();
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask

   // Bounded wait; a hang counts as a mismatch and closes the run
   task automatic wait_irq(output int n);
      n = 0;
      while (irq !== 1'b1 && n < 2000) begin
         @(negedge core_clk_i);
         n++;
      end
      if (n >= 2000) begin
         n_mismatch++;
         end_of_test();
      end
   endtask

   task automatic wr_mode(input logic [7:0] d);
      mode_wr_i = 1'b1;
      mode_data_i = d;
      @(negedge core_clk_i);
      mode_wr_i = 1'b0;
   endtask

   task automatic clr_flag();
      flag_clr_i = 1'b1;
      @(negedge core_clk_i);
      flag_clr_i = 1'b0;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      cyc(10);
      sys_rst_i = 1'b0;
      cyc(1);
      check("reset result", result, 12'h000);
      check("reset mode", mode_o, 12'h000);
      check("reset flag", flag, 12'h000);
      level = $random(seed);
      // Booster first, then let the reference settle before enabling
      wr_mode(8'h01);
      cyc(1400);
      // Booster already settled, so even the first result is usable
      wr_mode(8'h81);
      check("booster", boost, 12'h001);
      check("mode", mode_o, 12'h081);
      cyc(SAMPLE_CYCLES - 1);
      check("sampling", sample, 12'h001);
      cyc(1);
      check("holding", sample, 12'h000);
      check("first trial", trial, 12'h080);
      wait_irq(cnt);
      check("conv time", cnt, CONV_CYCLES - SAMPLE_CYCLES);
      check("result", result, level);
      check("flag set", flag, 12'h001);
      check("irq with store", irq, 12'h001);
      // Channel change keeps the flag and restarts the conversion
      level = $random(seed);
      ch = $random(seed);
      chan_wr_i = 1'b1;
      chan_data_i = ch;
      @(negedge core_clk_i);
      chan_wr_i = 1'b0;
      check("flag kept", flag, 12'h001);
      check("channel", chan_o, ch);
      check("restart", sample, 12'h001);
      clr_flag();
      check("flag clear", flag, 12'h000);
      wait_irq(cnt);
      check("restart time", cnt, CONV_CYCLES - 1);
      check("new result", result, level);
      // Read lands on the completion edge: old value out, store one cycle later
      old = result;
      level = $random(seed);
      cyc(CONV_CYCLES - 1);
      result_rd_i = 1'b1;
      @(negedge core_clk_i);
      result_rd_i = 1'b0;
      check("read first", rd_data, old);
      check("irq deferred", irq, 12'h000);
      cyc(1);
      check("late irq", irq, 12'h001);
      check("late store", result, level);
      cyc(1);
      wait_irq(cnt);
      // Mode write on the completion edge wins over the store
      old = result;
      level = $random(seed);
      cyc(CONV_CYCLES - 1);
      wr_mode(8'h81);
      check("no irq", irq, 12'h000);
      cyc(1);
      check("no irq late", irq, 12'h000);
      check("no store", result, old);
      wait_irq(cnt);
      check("after write", cnt, CONV_CYCLES - 1);
      // Results are read while running, never across a stop
      check("running read", result, level);
      clr_flag();
      // Clear lands on the next completion edge: the set has to win
      cyc(CONV_CYCLES - 2);
      clr_flag();
      check("set wins", flag, 12'h001);
      check("set wins irq", irq, 12'h001);
      cyc(1);
      clr_flag();
      cyc(50);
      standby_i = 1'b1;
      cyc(2);
      check("standby stop", busy, 12'h000);
      cyc(1500);
      check("standby no end", flag, 12'h000);
      standby_i = 1'b0;
      wr_mode(8'h00);
      cyc(2);
      check("disabled", busy, 12'h000);
      // Clear the flag before restarting a stopped converter
      clr_flag();
      check("flag before restart", flag, 12'h000);
      level = $random(seed);
      wr_mode(8'hC7);
      cyc(20);
      check("await trigger", busy, 12'h000);
      ext_trigger_i = 1'b1;
      cyc(6);
      check("trigger start", sample, 12'h001);
      cyc(300);
      ext_trigger_i = 1'b0;
      wait_irq(cnt);
      check("trig result", result, level);
      cyc(20);
      check("edge ignored", busy, 12'h000);
      end_of_test();
   end
endmodule
